// >>> stop_timestamp_pkg.sv
// Shared constants and types for the stop timestamping core
`default_nettype none
package stop_timestamp_pkg;
  localparam int NUM_CH = 4;
  localparam int PAIRS = NUM_CH / 2;
  localparam int CH_W = 2;
  localparam int ADDR_W = 8;
  localparam int PIDX_W = 20;
  localparam int FRAC_W = 24;
  localparam int PER_W = 24;
  localparam int ACC_W = FRAC_W + 2;
  localparam int LEFT_W = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SUBDIV = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_REF_PERIOD = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_RES_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RES_END = 8'h30;
  localparam int RES_CH_LSB = 3;
  localparam int RES_FRAC_BIT = 2;

  // Control register fields
  localparam int CTRL_PAIR_LSB = 0;
  localparam int CTRL_AVG_LSB = 2;
  localparam logic [1:0] AVG_ONE = 2'h0;
  localparam logic [1:0] AVG_FOUR = 2'h2;

  // Status register fields
  localparam int STAT_READY_LSB = 0;
  localparam int STAT_EMPTY_LSB = 4;
  localparam int STAT_BUSY_LSB = 8;

  localparam logic [FRAC_W-1:0] SUBDIV_RST = 24'h001F40;
  localparam logic [PIDX_W-1:0] EMPTY_MARK = 20'hFFFFF;

  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {PAIR_NONE, PAIR_ALTERNATE, PAIR_WIDTH} pairing_t;

  typedef struct packed {
    logic [1:0] avg;
    pairing_t pair;
  } ctrl_t;

  typedef struct packed {
    logic [PIDX_W-1:0] pidx;
    logic [FRAC_W-1:0] frac;
  } result_t;
endpackage : stop_timestamp_pkg
`default_nettype wire

// >>> stop_timestamp_channels.sv
// Four-channel stop timestamping core with AHB-Lite register access
// How it works
// - Stamp stop against latest preceding reference edge
// - Measure reference period continuously
// - Count reference periods, attach count to stop
// - One record, fraction plus index, per stop
// - Period index is twenty bits wide
// - Fraction is scaled ratio, below subdivision count
// - Averaging takes two or four samples
// - Averaging costs latency, spacing and queue depth
// - Alternating pairing feeds two channels from one pin
// - Alternating pairing hands edges out in turn
// - Alternating pair ready only when both hold results
// - Pairing doubles queue storage per pin
// - Averaging lengthens regular spacing and latency, cuts queue depth
// - Edge split joins channels one and three
// - Rising edges first channel, falling edges second
// - Edge split pair ready together after both edges
// - Averaging keeps minimum high pulse width
// - Empty channel reads all-ones marker
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`default_nettype none
module stop_timestamp_channels
  import stop_timestamp_pkg::*;
#(
  parameter int QDEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic reference_clock_pin,
  input wire logic [NUM_CH-1:0] stop_pin,
  output logic [NUM_CH-1:0] result_ready
);
  localparam int PTR_W = $clog2(QDEPTH);
  localparam int CNT_W = $clog2(QDEPTH + 1);

  function automatic logic [FRAC_W-1:0] scale(input logic [PER_W-1:0] since,
                                               input logic [PER_W-1:0] per,
                                               input logic [FRAC_W-1:0] div);
    logic [47:0] prod;
    logic [47:0] q;
    prod = 48'(since) * 48'(div);
    q = (per == '0) ? '0 : prod / 48'(per);
    // Clamp keeps the fraction below the subdivision count at edge ties
    if (q >= 48'(div)) q = (div == '0) ? '0 : 48'(div) - 48'(1);
    return q[FRAC_W-1:0];
  endfunction : scale

  function automatic logic res_hit(input logic [ADDR_W-1:0] a);
    return (a >= OFF_RES_BASE) && (a < OFF_RES_END);
  endfunction : res_hit

  function automatic logic [CH_W-1:0] res_chan(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a - OFF_RES_BASE;
    return rel[RES_CH_LSB +: CH_W];
  endfunction : res_chan

  // Pin synchronisers; the top bit carries the reference clock
  logic [NUM_CH:0] sync1_q, sync2_q, sync3_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {reference_clock_pin, stop_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic ref_rise;
  logic [NUM_CH-1:0] rise, fall;
  assign ref_rise = sync2_q[NUM_CH] & ~sync3_q[NUM_CH];
  assign rise = sync2_q[NUM_CH-1:0] & ~sync3_q[NUM_CH-1:0];
  assign fall = ~sync2_q[NUM_CH-1:0] & sync3_q[NUM_CH-1:0];

  // Reference period measurement and period index
  logic [PIDX_W-1:0] pidx_q, pidx_d, eff_idx;
  logic [PER_W-1:0] since_q, since_d, per_q, per_d, eff_since;
  logic seen_q, seen_d;
  always_comb begin
    pidx_d = pidx_q;
    per_d = per_q;
    seen_d = seen_q;
    since_d = (since_q == '1) ? since_q : since_q + PER_W'(1);
    eff_idx = pidx_q;
    eff_since = since_q;
    if (ref_rise) begin
      since_d = PER_W'(1);
      pidx_d = pidx_q + PIDX_W'(1);
      seen_d = 1'b1;
      if (seen_q) per_d = since_q;
      // A stop in the edge cycle belongs to this edge, never a later one
      eff_idx = pidx_d;
      eff_since = '0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pidx_q <= '0;
      per_q <= '0;
      since_q <= '0;
      seen_q <= 1'b0;
    end else begin
      pidx_q <= pidx_d;
      per_q <= per_d;
      since_q <= since_d;
      seen_q <= seen_d;
    end
  end

  // Configuration and bus
  ctrl_t ctrl_q, ctrl_d;
  logic [FRAC_W-1:0] subdiv_q, subdiv_d;
  logic wr_pend_q, wr_pend_d, addr_ok, rd_go;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d, a;
  logic [31:0] hrdata_q, hrdata_d;
  logic [NUM_CH-1:0] ev, empty, busy, pop, start, fin, ready_c, ready_q;
  logic [PAIRS-1:0] tog_q, tog_d;
  result_t head [NUM_CH];
  result_t samp [NUM_CH];
  result_t pushv [NUM_CH];

  assign a = haddr[ADDR_W-1:0];
  assign addr_ok = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
  assign rd_go = addr_ok & ~hwrite;

  always_comb begin
    ctrl_d = ctrl_q;
    subdiv_d = subdiv_q;
    wr_pend_d = addr_ok & hwrite & (hsize == HSIZE_WORD);
    wr_addr_d = a;
    hrdata_d = hrdata_q;
    pop = '0;
    if (wr_pend_q && wr_addr_q == OFF_CTRL) begin
      ctrl_d.pair = (hwdata[CTRL_PAIR_LSB +: 2] > PAIR_WIDTH) ? PAIR_NONE
                    : pairing_t'(hwdata[CTRL_PAIR_LSB +: 2]);
      ctrl_d.avg = (hwdata[CTRL_AVG_LSB +: 2] > AVG_FOUR) ? AVG_FOUR
                   : hwdata[CTRL_AVG_LSB +: 2];
    end
    if (wr_pend_q && wr_addr_q == OFF_SUBDIV) subdiv_d = hwdata[FRAC_W-1:0];
    if (rd_go) begin
      hrdata_d = '0;
      if (a == OFF_CTRL) begin
        hrdata_d[CTRL_PAIR_LSB +: 2] = ctrl_q.pair;
        hrdata_d[CTRL_AVG_LSB +: 2] = ctrl_q.avg;
      end else if (a == OFF_SUBDIV) begin
        hrdata_d[FRAC_W-1:0] = subdiv_q;
      end else if (a == OFF_STATUS) begin
        hrdata_d[STAT_READY_LSB +: NUM_CH] = ready_q;
        hrdata_d[STAT_EMPTY_LSB +: NUM_CH] = empty;
        hrdata_d[STAT_BUSY_LSB +: NUM_CH] = busy;
      end else if (a == OFF_REF_PERIOD) begin
        hrdata_d[PER_W-1:0] = per_q;
      end else if (res_hit(a)) begin
        if (empty[res_chan(a)]) begin
          hrdata_d[PIDX_W-1:0] = EMPTY_MARK;
        end else if (a[RES_FRAC_BIT]) begin
          hrdata_d[FRAC_W-1:0] = head[res_chan(a)].frac;
          // Reading the fraction word retires the record
          pop[res_chan(a)] = 1'b1;
        end else begin
          hrdata_d[PIDX_W-1:0] = head[res_chan(a)].pidx;
        end
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= '{avg: AVG_ONE, pair: PAIR_NONE};
      subdiv_q <= SUBDIV_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      subdiv_q <= subdiv_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;

  // Steering of pin edges onto channels and readiness per pairing mode
  always_comb begin
    ev = rise;
    tog_d = '0;
    ready_c = ~empty;
    unique case (ctrl_q.pair)
      PAIR_NONE: begin
      end
      PAIR_ALTERNATE: begin
        for (int p = 0; p < PAIRS; p++) begin
          ev[p] = rise[p] & ~tog_q[p];
          ev[p + PAIRS] = rise[p] & tog_q[p];
          tog_d[p] = tog_q[p] ^ rise[p];
          ready_c[p] = ~empty[p] & ~empty[p + PAIRS];
          ready_c[p + PAIRS] = ready_c[p];
        end
      end
      PAIR_WIDTH: begin
        ev[PAIRS] = fall[0];
        ready_c[0] = ~empty[0] & ~empty[PAIRS];
        ready_c[PAIRS] = ready_c[0];
      end
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_q <= '0;
      ready_q <= '0;
    end else begin
      tog_q <= tog_d;
      ready_q <= ready_c;
    end
  end
  assign result_ready = ready_q;

  // Per channel: averaging stage, then a result queue
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic busy_q, busy_d;
    logic [LEFT_W-1:0] left_q, left_d;
    logic [1:0] shift_q, shift_d;
    logic [ACC_W-1:0] acc_q, acc_d, sum;
    result_t samp_q, samp_d;
    result_t mem_q [QDEPTH];
    logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, lim;
    logic push;

    // A busy channel ignores new edges: that is the regular spacing
    assign start[i] = ev[i] & ~busy_q;
    assign fin[i] = busy_q & (left_q == '0);
    assign sum = acc_q + ACC_W'(samp_q.frac);
    assign samp[i] = samp_q;
    assign pushv[i] = '{pidx: samp_q.pidx, frac: FRAC_W'(sum >> shift_q)};
    // Averaging shrinks the usable depth of each queue
    assign lim = CNT_W'(QDEPTH >> ctrl_q.avg);
    assign push = fin[i] & (cnt_q < lim);
    assign busy[i] = busy_q;
    assign empty[i] = (cnt_q == '0);
    assign head[i] = mem_q[rd_q];

    always_comb begin
      busy_d = busy_q;
      left_d = left_q;
      shift_d = shift_q;
      acc_d = acc_q;
      samp_d = samp_q;
      if (start[i]) begin
        busy_d = 1'b1;
        left_d = LEFT_W'((1 << ctrl_q.avg) - 1);
        shift_d = ctrl_q.avg;
        acc_d = '0;
        samp_d.pidx = eff_idx;
        samp_d.frac = scale(eff_since, per_q, subdiv_q);
      end else if (busy_q) begin
        // Each pass re-reads the held sample; the delay line itself is analog
        acc_d = sum;
        left_d = left_q - LEFT_W'(1);
        if (fin[i]) busy_d = 1'b0;
      end
      wr_d = push ? wr_q + PTR_W'(1) : wr_q;
      rd_d = pop[i] ? rd_q + PTR_W'(1) : rd_q;
      cnt_d = cnt_q + CNT_W'(push) - CNT_W'(pop[i]);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        busy_q <= 1'b0;
        left_q <= '0;
        shift_q <= '0;
        acc_q <= '0;
        samp_q <= '0;
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        busy_q <= busy_d;
        left_q <= left_d;
        shift_q <= shift_d;
        acc_q <= acc_d;
        samp_q <= samp_d;
        wr_q <= wr_d;
        rd_q <= rd_d;
        cnt_q <= cnt_d;
      end
    end
    always_ff @(posedge hclk) begin
      if (push) mem_q[wr_q] <= pushv[i];
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_start_four;
    start[0] && ctrl_q.avg == AVG_FOUR;
  endsequence
  sequence s_width_held;
    ctrl_q.pair == PAIR_WIDTH ##1 ctrl_q.pair == PAIR_WIDTH;
  endsequence

  a_index_steps: assert property (ref_rise |=> pidx_q == $past(pidx_q) + PIDX_W'(1))
    else $error("period index did not step on reference edge");
  a_index_wraps: assert property (ref_rise && pidx_q == '1 |=> pidx_q == '0)
    else $error("period index did not wrap to zero");
  a_stamp_preceding: assert property (start[0] && !ref_rise |=> samp[0].pidx == $past(pidx_q))
    else $error("stop stamped with wrong period index");
  a_frac_below: assert property (fin[0] && subdiv_q != '0 |-> pushv[0].frac < subdiv_q)
    else $error("fraction not below subdivision count");
  a_avg_four: assert property (s_start_four |-> !fin[0] [*4] ##1 fin[0])
    else $error("four-sample averaging did not finish after four cycles");
  a_alt_route: assert property (ctrl_q.pair == PAIR_ALTERNATE && rise[0]
                                |-> ev[0] != ev[PAIRS] && ev[PAIRS] == tog_q[0])
    else $error("alternating edge routed to wrong channel");
  a_alt_ready: assert property (ctrl_q.pair == PAIR_ALTERNATE && empty[PAIRS]
                                |=> !result_ready[0])
    else $error("paired channel ready while partner empty");
  a_width_split: assert property (ctrl_q.pair == PAIR_WIDTH && fall[0]
                                  |-> ev[PAIRS] && !ev[0])
    else $error("falling edge not routed to second channel");
  a_width_ready: assert property (s_width_held |-> result_ready[0] == result_ready[PAIRS])
    else $error("edge split pair not ready together");
  a_empty_marker: assert property (rd_go && res_hit(a) && empty[res_chan(a)]
                                   |=> hrdata[PIDX_W-1:0] == EMPTY_MARK)
    else $error("empty channel did not read marker");
endmodule : stop_timestamp_channels
`default_nettype wire

// >>> stop_source.sv
// Reference clock and stop pulse source facing the timestamping core
`default_nettype none
module stop_source
  import stop_timestamp_pkg::*;
#(
  parameter int REF_PER = 40,
  parameter int GAP = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic reference_clock_pin,
  output logic [NUM_CH-1:0] stop_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int phase_q;
  int ref_cnt_q;
  int quiet_q;

  initial begin
    stop_pin = '0;
    reference_clock_pin = 1'b0;
  end

  // Reference runs free, also between stop pulses
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 0;
      ref_cnt_q <= 0;
      quiet_q <= GAP;
      reference_clock_pin <= 1'b0;
    end else begin
      phase_q <= (phase_q == REF_PER - 1) ? 0 : phase_q + 1;
      if (phase_q == REF_PER - 1) begin
        ref_cnt_q <= ref_cnt_q + 1;
        reference_clock_pin <= 1'b1;
      end
      if (phase_q == REF_PER / 2 - 1) begin
        reference_clock_pin <= 1'b0;
      end
      quiet_q <= (stop_pin != '0) ? 0 : quiet_q + 1;
    end
  end

  // Stamp a stop would get if it rises at the coming edge
  function automatic result_t predict(input logic [FRAC_W-1:0] sub);
    int ph;
    int cnt;
    ph = (phase_q == REF_PER - 1) ? 0 : phase_q + 1;
    cnt = (phase_q == REF_PER - 1) ? ref_cnt_q + 1 : ref_cnt_q;
    predict.pidx = PIDX_W'(cnt);
    predict.frac = FRAC_W'((longint'(ph) * sub) / REF_PER);
  endfunction : predict

  task automatic pulse(input int pin, input int width, input logic [FRAC_W-1:0] sub,
                       output result_t rise_r, output result_t fall_r);
    do @(negedge hclk); while (quiet_q < GAP);
    rise_r = predict(sub);
    @(posedge hclk);
    stop_pin[pin] <= 1'b1;
    repeat (width - 1) @(posedge hclk);
    @(negedge hclk);
    fall_r = predict(sub);
    @(posedge hclk);
    stop_pin[pin] <= 1'b0;
  endtask : pulse
endmodule : stop_source
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the stop timestamping core
`default_nettype none
module tb_top
  import stop_timestamp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REF_PER = 40;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic reference_clock_pin;
  logic [NUM_CH-1:0] stop_pin;
  logic [NUM_CH-1:0] result_ready;
  int fail_count = 0;
  int n_checks = 0;
  result_t exp_q[NUM_CH][$];
  logic [FRAC_W-1:0] subdiv = SUBDIV_RST;
  result_t last_rec[NUM_CH];
  int dt = 0;

  always #4 hclk = ~hclk;

  stop_timestamp_channels #(.QDEPTH(8)) stop_timestamp_channels_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .reference_clock_pin(reference_clock_pin), .stop_pin(stop_pin),
    .result_ready(result_ready)
  );

  stop_source #(.REF_PER(REF_PER), .GAP(12)) stop_source_i (
    .hclk(hclk), .hresetn(hresetn), .reference_clock_pin(reference_clock_pin),
    .stop_pin(stop_pin)
  );

  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wait_hready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      finish_test();
    end
  endtask : wait_hready

  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_hready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_hready();
    rd = hrdata;
    cmp({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : ahb_xfer

  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ahb_xfer(1'b0, a, 32'h0, d);
    cmp(d, exp);
  endtask : rd_cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb_xfer(1'b1, a, wd, d);
  endtask : wr

  // An empty queue must read the marker in both words
  task automatic check_rec(input int ch);
    result_t e;
    logic [31:0] d;
    e.pidx = EMPTY_MARK;
    e.frac = FRAC_W'(EMPTY_MARK);
    if (exp_q[ch].size() > 0) begin
      e = exp_q[ch].pop_front();
    end
    ahb_xfer(1'b0, OFF_RES_BASE + 8'(8 * ch), 32'h0, d);
    cmp(d, {12'h0, e.pidx});
    last_rec[ch].pidx = d[PIDX_W-1:0];
    ahb_xfer(1'b0, OFF_RES_BASE + 8'(8 * ch + 4), 32'h0, d);
    cmp(d, {8'h0, e.frac});
    last_rec[ch].frac = d[FRAC_W-1:0];
  endtask : check_rec

  task automatic wait_ready(input logic [NUM_CH-1:0] m);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while ((result_ready & m) !== m && n < 100);
    cmp({28'h0, result_ready & m}, {28'h0, m});
    if ((result_ready & m) !== m) begin
      finish_test();
    end
    @(posedge hclk);
  endtask : wait_ready

  task automatic sp(input int pin, input int width, input int ch_r, input int ch_f);
    result_t r;
    result_t f;
    stop_source_i.pulse(pin, width, subdiv, r, f);
    if (ch_r >= 0) exp_q[ch_r].push_back(r);
    if (ch_f >= 0) exp_q[ch_f].push_back(f);
  endtask : sp

  task automatic ready_low(input int edges, input logic [NUM_CH-1:0] m);
    repeat (edges) @(posedge hclk);
    @(negedge hclk);
    cmp({28'h0, result_ready & m}, 32'h0);
    @(posedge hclk);
  endtask : ready_low

  initial begin
    repeat (100000) @(posedge hclk);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_cmp(OFF_CTRL, 32'h0);
    rd_cmp(OFF_SUBDIV, {8'h0, SUBDIV_RST});
    rd_cmp(OFF_STATUS, 32'h000000F0);
    rd_cmp(8'h40, 32'h0);
    check_rec(0);
    cmp({28'h0, result_ready}, 32'h0);
    repeat (3 * REF_PER) @(posedge hclk);
    rd_cmp(OFF_REF_PERIOD, 32'(REF_PER));
    // Independent channels at assorted phases, one record each
    for (int k = 0; k < NUM_CH; k++) begin
      repeat (7 * k) @(posedge hclk);
      sp(k, 3, k, -1);
    end
    wait_ready(4'hF);
    for (int k = 0; k < NUM_CH; k++) begin
      check_rec(k);
      check_rec(k);
    end
    // Four samples: result unchanged, but it arrives later
    subdiv = 24'h000064;
    wr(OFF_SUBDIV, 32'h00000064);
    wr(OFF_CTRL, {28'h0, AVG_FOUR, 2'h0});
    sp(0, 2, 0, -1);
    ready_low(4, 4'h1);
    wait_ready(4'h1);
    check_rec(0);
    // Two samples: ready comes one cycle later than with a single sample
    wr(OFF_CTRL, {28'h0, 2'h1, 2'h0});
    sp(1, 2, 1, -1);
    ready_low(3, 4'h2);
    wait_ready(4'h2);
    check_rec(1);
    // Alternating pairs on the shared pin, with averaging kept on
    wr(OFF_CTRL, {28'h0, AVG_FOUR, 2'h1});
    sp(2, 2, -1, -1);
    sp(0, 2, 0, -1);
    ready_low(20, 4'h5);
    sp(0, 2, 2, -1);
    wait_ready(4'h5);
    check_rec(0);
    check_rec(2);
    check_rec(0);
    check_rec(2);
    // Edge split: rise to the first channel, fall to the partner
    wr(OFF_CTRL, 32'h2);
    sp(0, 8, 0, 2);
    ready_low(0, 4'h5);
    wait_ready(4'h5);
    check_rec(0);
    check_rec(2);
    // Host arithmetic on the read records: the pulse was high for eight clocks
    dt = int'(last_rec[2].frac) - int'(last_rec[0].frac);
    dt = dt + (int'(last_rec[2].pidx) - int'(last_rec[0].pidx)) * int'(subdiv);
    cmp(32'(dt), 32'(8 * int'(subdiv) / REF_PER));
    dt = int'(last_rec[2].frac) - int'(last_rec[0].frac);
    if (dt < 0) dt = dt + int'(subdiv);
    cmp(32'(dt), 32'(8 * int'(subdiv) / REF_PER));
    rd_cmp(OFF_STATUS, 32'h000000F0);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
